// *** core/mdcr_defs.svh ***
`ifndef MDCR_DEFS_SVH
`define MDCR_DEFS_SVH

// register indices on the serial port
`define MDCR_IDX_THRESH      8'h15
`define MDCR_IDX_NVCTL       8'h1C
`define MDCR_IDX_MASK        8'h1D
`define MDCR_IDX_FAULT_OUTPUT_PIN        8'h1E
`define MDCR_IDX_RUN         8'h1F

// field positions
`define MDCR_STORE_BIT       9
`define MDCR_MASK_HI         9
`define MDCR_MASK_LO         3
`define MDCR_SEL_HI_HI       4
`define MDCR_SEL_HI_LO       2
`define MDCR_RUN_SEL_HI      9
`define MDCR_RUN_SEL_LO      8
`define MDCR_RUN_LATCH       7
`define MDCR_RUN_STANDBY     6
`define MDCR_RUN_STARTUP     5
`define MDCR_RUN_ACTION      4
`define MDCR_RUN_RESTART     3
`define MDCR_RUN_BRAKE       2
`define MDCR_RUN_DIR         1
`define MDCR_RUN_GO          0

// fault output selector codes
`define MDCR_SEL_GENERAL     5'h00
`define MDCR_SEL_DESYNC      5'h01
`define MDCR_SEL_TEMP        5'h02
`define MDCR_SEL_CLOCK       5'h03
`define MDCR_SEL_PWM0        5'h09
`define MDCR_SEL_WD_TIMEOUT  5'h0F
`define MDCR_SEL_WD_ACTIVE   5'h10
`define MDCR_SEL_GATE        5'h11
`define MDCR_SEL_GATE_RST    5'h12
`define MDCR_SEL_HARD_OC     5'h13
`define MDCR_SEL_QCURRENT    5'h14

// reset values
`define MDCR_RST_THRESH      10'h0AE
`define MDCR_RST_MASK        7'h00
`define MDCR_RST_SEL_HI      3'h0
`define MDCR_RST_RUN         10'h092
`define MDCR_DEV_ADDR        7'h2A

`endif

// *** core/mdcr_pkg.sv ***
package mdcr_pkg;
    typedef logic [6:0] mdcr_flags_lo_t;   // thermal warn .. supply undervoltage
    typedef logic [4:0] mdcr_flags_hi_t;   // general, logic uv, storage, watchdog, soft oc
    typedef enum logic [2:0] {
        MDCR_IDLE,
        MDCR_ADDR,
        MDCR_PTR,
        MDCR_WR,
        MDCR_RD
    } mdcr_link_state_t;
endpackage : mdcr_pkg

// *** core/mdcr_regs.sv ***
// Overview of operation
// - 10-bit threshold sets low power entry voltage
// - store bit falling, stopped, unlocked: save config
// - counter increments after each completed save
// - write limit flag sets permanently past 1023
// - mask bit one disables its diagnostic
// - mask bits sit at 9 down to 3
// - status bits set on detection, fixed layout
// - fault pin low when selected source detected
// - selector codes map to listed sources
// - run register layout, selector low bits 9:8
// - latch select zero clears status, blocks restart
// - standby select zero: clear pin stands gate drive
// - startup select chooses ramp or alignment start
// - fault action one turns off all switches
// - every read carries six critical flags on top
// - run bit zero stops motor, gates saving
`include "mdcr_defs.svh"

module mdcr_regs #(
    parameter logic [6:0] DEV_ADDR = `MDCR_DEV_ADDR
) (
    input  wire logic                   clock,
    input  wire logic                   rst,
    input  wire logic                   scl_in,
    input  wire logic                   sda_in,
    output logic                        sda_out,
    output logic                        sda_oe,
    input  wire logic                   external_clear_pin_n,
    input  wire logic [9:0]             speed_voltage_code,
    input  wire mdcr_pkg::mdcr_flags_lo_t fault_evt_lo,
    input  wire mdcr_pkg::mdcr_flags_hi_t fault_evt_hi,
    input  wire logic                   config_unlocked,
    input  wire logic                   nv_store_done,
    input  wire logic [5:0]             pwm_drive,
    input  wire logic                   die_temp_tap,
    input  wire logic                   clock_tap,
    input  wire logic                   wd_active,
    input  wire logic                   gate_fault_reset,
    input  wire logic                   q_current_tap,
    output logic                        nv_store_start,
    output logic                        fault_output_pin_n,
    output logic                        low_power_mode,
    output logic                        gate_standby,
    output logic                        power_switch_off,
    output logic                        dc_align_start,
    output logic                        restart_enable,
    output logic                        brake,
    output logic                        direction,
    output logic                        motor_run
);
    import mdcr_pkg::*;

    logic [1:0]       pins_s;
    logic             clr_s;
    logic             scl_d_r;
    logic             sda_d_r;
    mdcr_link_state_t state_r;
    logic [3:0]       cnt_r;
    logic [7:0]       sh_r;
    logic [7:0]       tx_r;
    logic [7:0]       ptr_r;
    logic [7:0]       hi_buf_r;
    logic             byte_sel_r;
    logic             nack_r;
    logic             wr_en_r;
    logic [15:0]      wr_data_r;
    logic [9:0]       thresh_r;
    logic             store_trig_r;
    logic             store_busy_r;
    logic [9:0]       store_cnt_r;
    logic             limit_r;
    logic [6:0]       mask_r;
    logic [2:0]       sel_hi_r;
    logic [9:0]       run_r;
    logic [6:0]       stat_lo_r;
    logic [5:0]       stat_hi_r;

    mdcr_sync #(.WIDTH(3)) u_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in ({scl_in, sda_in, external_clear_pin_n}),
        .sync_out ({pins_s, clr_s})
    );

    wire scl       = pins_s[1];
    wire sda       = pins_s[0];
    wire scl_rise  = scl & ~scl_d_r;
    wire scl_fall  = ~scl & scl_d_r;
    wire start_det = scl & scl_d_r & sda_d_r & ~sda;
    wire stop_det  = scl & scl_d_r & ~sda_d_r & sda;
    wire [7:0] rx_byte = sh_r;

    // register decode
    wire hit_thresh = ptr_r == `MDCR_IDX_THRESH;
    wire hit_nvctl  = ptr_r == `MDCR_IDX_NVCTL;
    wire hit_mask   = ptr_r == `MDCR_IDX_MASK;
    wire hit_fault_output_pin   = ptr_r == `MDCR_IDX_FAULT_OUTPUT_PIN;
    wire hit_run    = ptr_r == `MDCR_IDX_RUN;

    // masked low faults, high faults never masked
    wire [6:0] evt_lo   = fault_evt_lo & ~mask_r;
    wire [5:0] evt_hi   = {fault_evt_hi, limit_r};
    wire       any_evt  = |evt_lo | |evt_hi;
    wire       latch_on = run_r[`MDCR_RUN_LATCH];
    // set wins over clear: events are or-ed into whatever survives
    wire [6:0] stat_lo_nxt = (latch_on ? stat_lo_r : 7'h00) | evt_lo;
    wire [5:0] stat_hi_nxt = (latch_on ? stat_hi_r : 6'h00) | evt_hi;

    wire [9:0] rd_low =
        hit_thresh ? thresh_r :
        hit_nvctl  ? store_cnt_r :
        hit_mask   ? {mask_r, 3'h0} :
        hit_fault_output_pin   ? {stat_lo_r, 3'h0} :
        hit_run    ? run_r :
        10'h000;
    wire [15:0] rd_word = {stat_hi_r, rd_low};

    // save request: store bit written one to zero while stopped and unlocked
    wire store_fall = wr_en_r && hit_nvctl && store_trig_r
                      && !wr_data_r[`MDCR_STORE_BIT];
    wire store_go   = store_fall && !run_r[`MDCR_RUN_GO]
                      && config_unlocked && !store_busy_r;

    // fault output source map, unlisted codes never assert
    wire [4:0] sel_code = {sel_hi_r, run_r[`MDCR_RUN_SEL_HI:`MDCR_RUN_SEL_LO]};
    logic [31:0] src_map;
    always_comb begin
        src_map = 32'h0000_0000;
        src_map[`MDCR_SEL_GENERAL]    = stat_hi_r[5];
        src_map[`MDCR_SEL_DESYNC]     = stat_lo_r[4];
        src_map[`MDCR_SEL_TEMP]       = die_temp_tap;
        src_map[`MDCR_SEL_CLOCK]      = clock_tap;
        src_map[`MDCR_SEL_PWM0 +: 6]  = pwm_drive;
        src_map[`MDCR_SEL_WD_TIMEOUT] = stat_hi_r[2];
        src_map[`MDCR_SEL_WD_ACTIVE]  = wd_active;
        src_map[`MDCR_SEL_GATE]       = stat_lo_r[3];
        src_map[`MDCR_SEL_GATE_RST]   = gate_fault_reset;
        src_map[`MDCR_SEL_HARD_OC]    = stat_lo_r[2];
        src_map[`MDCR_SEL_QCURRENT]   = q_current_tap;
    end

    // serial link: byte engine
    always_ff @(posedge clock) begin
        if (rst) begin
            scl_d_r    <= 1'b1;
            sda_d_r    <= 1'b1;
            state_r    <= MDCR_IDLE;
            cnt_r      <= 4'h0;
            sh_r       <= 8'h00;
            tx_r       <= 8'h00;
            ptr_r      <= 8'h00;
            hi_buf_r   <= 8'h00;
            byte_sel_r <= 1'b0;
            nack_r     <= 1'b0;
            sda_oe     <= 1'b0;
            sda_out    <= 1'b0;
            wr_en_r    <= 1'b0;
            wr_data_r  <= 16'h0000;
        end else begin
            scl_d_r <= scl;
            sda_d_r <= sda;
            wr_en_r <= 1'b0;
            if (start_det) begin
                state_r    <= MDCR_ADDR;
                cnt_r      <= 4'h0;
                byte_sel_r <= 1'b0;
                sda_oe     <= 1'b0;
            end else if (stop_det) begin
                state_r <= MDCR_IDLE;
                sda_oe  <= 1'b0;
            end else if (state_r != MDCR_IDLE && scl_rise) begin
                cnt_r <= cnt_r + 4'h1;
                if (cnt_r < 4'h8) begin
                    sh_r <= {sh_r[6:0], sda};
                end else begin
                    nack_r <= sda;
                end
            end else if (state_r != MDCR_IDLE && scl_fall) begin
                if (cnt_r == 4'h8) begin
                    sda_oe <= 1'b0;
                    case (state_r)
                        MDCR_ADDR: begin
                            sda_oe <= rx_byte[7:1] == DEV_ADDR;
                            if (rx_byte[7:1] != DEV_ADDR) begin
                                state_r <= MDCR_IDLE;
                            end
                        end
                        MDCR_PTR: begin
                            ptr_r  <= rx_byte;
                            sda_oe <= 1'b1;
                        end
                        MDCR_WR: begin
                            sda_oe <= 1'b1;
                            if (!byte_sel_r) begin
                                hi_buf_r <= rx_byte;
                            end else begin
                                wr_data_r <= {hi_buf_r, rx_byte};
                                wr_en_r   <= 1'b1;
                            end
                        end
                        default: begin
                        end
                    endcase
                end else if (cnt_r == 4'h9) begin
                    cnt_r  <= 4'h0;
                    sda_oe <= 1'b0;
                    case (state_r)
                        MDCR_ADDR: begin
                            state_r    <= sh_r[0] ? MDCR_RD : MDCR_PTR;
                            byte_sel_r <= 1'b1;
                            if (sh_r[0]) begin
                                tx_r   <= rd_word[15:8];
                                sda_oe <= ~rd_word[15];
                            end
                        end
                        MDCR_PTR: begin
                            state_r    <= MDCR_WR;
                            byte_sel_r <= 1'b0;
                        end
                        MDCR_WR: begin
                            byte_sel_r <= ~byte_sel_r;
                        end
                        MDCR_RD: begin
                            // master nack ends the read burst
                            if (nack_r) begin
                                state_r <= MDCR_IDLE;
                            end else begin
                                tx_r       <= byte_sel_r ? rd_word[7:0] : rd_word[15:8];
                                sda_oe     <= byte_sel_r ? ~rd_word[7] : ~rd_word[15];
                                byte_sel_r <= ~byte_sel_r;
                            end
                        end
                        default: begin
                            state_r <= MDCR_IDLE;
                        end
                    endcase
                end else if (state_r == MDCR_RD) begin
                    tx_r   <= {tx_r[6:0], 1'b0};
                    sda_oe <= ~tx_r[6];
                end
            end
        end
    end

    // register file
    always_ff @(posedge clock) begin
        if (rst) begin
            thresh_r     <= `MDCR_RST_THRESH;
            store_trig_r <= 1'b0;
            mask_r       <= `MDCR_RST_MASK;
            sel_hi_r     <= `MDCR_RST_SEL_HI;
            run_r        <= `MDCR_RST_RUN;
        end else if (wr_en_r) begin
            if (hit_thresh) begin
                thresh_r <= wr_data_r[9:0];
            end
            if (hit_nvctl) begin
                store_trig_r <= wr_data_r[`MDCR_STORE_BIT];
            end
            if (hit_mask) begin
                mask_r <= wr_data_r[`MDCR_MASK_HI:`MDCR_MASK_LO];
            end
            if (hit_fault_output_pin) begin
                sel_hi_r <= wr_data_r[`MDCR_SEL_HI_HI:`MDCR_SEL_HI_LO];
            end
            if (hit_run) begin
                run_r <= wr_data_r[9:0];
            end
        end
    end

    // nonvolatile save sequencing and wear tracking
    always_ff @(posedge clock) begin
        if (rst) begin
            store_busy_r   <= 1'b0;
            nv_store_start <= 1'b0;
            store_cnt_r    <= 10'h000;
            limit_r        <= 1'b0;
        end else begin
            nv_store_start <= store_go;
            if (store_go) begin
                store_busy_r <= 1'b1;
            end else if (store_busy_r && nv_store_done) begin
                store_busy_r <= 1'b0;
                store_cnt_r  <= store_cnt_r + 10'h001;
                if (&store_cnt_r) begin
                    limit_r <= 1'b1;
                end
            end
        end
    end

    // status and drive outputs
    always_ff @(posedge clock) begin
        if (rst) begin
            stat_lo_r          <= 7'h00;
            stat_hi_r          <= 6'h00;
            fault_output_pin_n <= 1'b1;
            low_power_mode     <= 1'b0;
            gate_standby       <= 1'b0;
            power_switch_off   <= 1'b0;
            dc_align_start     <= 1'b0;
            restart_enable     <= 1'b0;
            brake              <= 1'b0;
            direction          <= 1'b0;
            motor_run          <= 1'b0;
        end else begin
            stat_lo_r          <= stat_lo_nxt;
            stat_hi_r          <= stat_hi_nxt;
            fault_output_pin_n <= ~src_map[sel_code];
            low_power_mode     <= speed_voltage_code <= thresh_r;
            gate_standby       <= ~run_r[`MDCR_RUN_STANDBY] & ~clr_s;
            power_switch_off   <= run_r[`MDCR_RUN_ACTION] & any_evt;
            dc_align_start     <= run_r[`MDCR_RUN_STARTUP];
            restart_enable     <= run_r[`MDCR_RUN_RESTART] & latch_on;
            brake              <= run_r[`MDCR_RUN_BRAKE] & run_r[`MDCR_RUN_GO];
            direction          <= run_r[`MDCR_RUN_DIR];
            motor_run          <= run_r[`MDCR_RUN_GO];
        end
    end
endmodule : mdcr_regs

// *** core/mdcr_sync.sv ***
module mdcr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clock) begin
        if (rst) begin
            meta_r   <= '1;
            sync_out <= '1;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : mdcr_sync

// *** tb/mdcr_host.sv ***
`include "mdcr_defs.svh"

module mdcr_host (
    input  wire logic clock,
    input  wire logic sda_line,
    output logic      scl_o,
    output logic      sda_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // data moves 3 clocks into the low phase so the synced copy sees scl low first
    task automatic bit_io(input logic b, output logic s);
        repeat (3) @(negedge clock);
        sda_o = b;
        @(negedge clock);
        scl_o = 1'b1;
        repeat (4) @(negedge clock);
        s = sda_line;
        scl_o = 1'b0;
    endtask : bit_io
    task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) bit_io(tx[i], rx[i]);
    endtask : byte_io
    task automatic start();
        if (!scl_o) begin
            repeat (3) @(negedge clock);
            sda_o = 1'b1;
            @(negedge clock);
            scl_o = 1'b1;
        end
        repeat (4) @(negedge clock);
        sda_o = 1'b0;
        repeat (4) @(negedge clock);
        scl_o = 1'b0;
    endtask : start
    task automatic stop();
        repeat (3) @(negedge clock);
        sda_o = 1'b0;
        @(negedge clock);
        scl_o = 1'b1;
        repeat (4) @(negedge clock);
        sda_o = 1'b1;
        repeat (4) @(negedge clock);
    endtask : stop
    task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [15:0] d,
                      output logic acked);
        logic [8:0] r0, r1, r2, r3;
        start();
        byte_io({a, 2'b01}, r0);
        byte_io({idx, 1'b1}, r1);
        byte_io({d[15:8], 1'b1}, r2);
        byte_io({d[7:0], 1'b1}, r3);
        stop();
        acked = !(r0[0] | r1[0] | r2[0] | r3[0]);
    endtask : wr
    task automatic rd(input logic [7:0] idx, output logic [15:0] q);
        logic [8:0] r0, r1, r2, r3;
        start();
        byte_io({`MDCR_DEV_ADDR, 2'b01}, r0);
        byte_io({idx, 1'b1}, r1);
        start();
        byte_io({`MDCR_DEV_ADDR, 2'b11}, r0);
        byte_io(9'h1fe, r2);
        // nack on the low byte ends the read
        byte_io(9'h1ff, r3);
        stop();
        q = {r2[8:1], r3[8:1]};
    endtask : rd
endmodule : mdcr_host

// *** tb/mdcr_regs_checker.sv ***
module mdcr_regs_checker (
    input wire logic                     clock,
    input wire logic                     rst,
    input wire logic                     scl_in,
    input wire logic                     sda_out,
    input wire logic                     sda_oe,
    input wire logic                     external_clear_pin_n,
    input wire mdcr_pkg::mdcr_flags_lo_t fault_evt_lo,
    input wire mdcr_pkg::mdcr_flags_hi_t fault_evt_hi,
    input wire logic                     config_unlocked,
    input wire logic [5:0]               pwm_drive,
    input wire logic                     die_temp_tap,
    input wire logic                     clock_tap,
    input wire logic                     wd_active,
    input wire logic                     gate_fault_reset,
    input wire logic                     q_current_tap,
    input wire logic                     nv_store_start,
    input wire logic                     fault_output_pin_n,
    input wire logic                     gate_standby,
    input wire logic                     power_switch_off,
    input wire logic                     dc_align_start,
    input wire logic                     brake,
    input wire logic                     direction,
    input wire logic                     motor_run
);
    timeunit 1ns;
    timeprecision 1ns;
    import mdcr_pkg::*;
    logic any_src;
    assign any_src = |{fault_evt_lo, fault_evt_hi, pwm_drive, die_temp_tap, clock_tap,
                       wd_active, gate_fault_reset, q_current_tap};
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    chk_store_pulse: assert property (
        nv_store_start |=> !nv_store_start) else $error("store start too long");
    chk_store_gate: assert property (
        nv_store_start |-> !$past(motor_run) && $past(config_unlocked))
        else $error("store started while running or locked");
    chk_standby_off: assert property (
        external_clear_pin_n [*4] |-> !gate_standby) else $error("standby without clear");
    chk_switch_idle: assert property (
        fault_evt_lo == '0 && fault_evt_hi == '0 |=> !power_switch_off)
        else $error("switches off without fault");
    chk_pin_cause: assert property (
        $fell(fault_output_pin_n) |-> $past(any_src) || !$past(scl_in, 2))
        else $error("fault pin low without source");
    chk_run_write: assert property (
        $changed({motor_run, direction, brake, dc_align_start}) && !$past(rst)
        && !$past(rst, 2) |-> !$past(scl_in, 2)) else $error("run outputs moved off a write");
    chk_ack_timing: assert property (
        $changed(sda_oe) |-> !$past(scl_in)) else $error("data line moved in clock high");
    chk_sda_low: assert property (
        sda_oe |-> sda_out == 1'b0) else $error("data line driven high");
endmodule : mdcr_regs_checker

bind mdcr_regs mdcr_regs_checker u_chk (.*);

// *** tb/testbench.sv ***
`include "mdcr_defs.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import mdcr_pkg::*;
    logic           clock, rst, scl_in, sda_in, sda_out, sda_oe, host_sda, ok;
    logic           external_clear_pin_n, config_unlocked, nv_store_done, nv_store_start;
    logic           die_temp_tap, clock_tap, wd_active, gate_fault_reset, q_current_tap;
    logic           fault_output_pin_n, low_power_mode, gate_standby, power_switch_off;
    logic           dc_align_start, restart_enable, brake, direction, motor_run;
    logic [9:0]     speed_voltage_code;
    logic [5:0]     pwm_drive;
    mdcr_flags_lo_t fault_evt_lo;
    mdcr_flags_hi_t fault_evt_hi;
    int             num_errors = 0;
    int             compares = 0;
    int             starts = 0;

    // open drain with pull-up: low wins
    assign sda_in = host_sda & (!sda_oe | sda_out);
    mdcr_regs u_dut (.*);
    mdcr_host u_host (.clock(clock), .sda_line(sda_in), .scl_o(scl_in), .sda_o(host_sda));

    initial clock = 1'b0;
    always #20 clock = ~clock;
    always @(posedge clock) if (nv_store_start === 1'b1) starts++;

    task automatic wrap_up();
        if (num_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] idx, input logic [15:0] d);
        u_host.wr(`MDCR_DEV_ADDR, idx, d, ok);
        check("ack", ok, 1'b1);
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] idx, input logic [15:0] exp);
        logic [15:0] q;
        u_host.rd(idx, q);
        check($sformatf("reg %h", idx), q, exp);
    endtask : rd_chk
    task automatic settle();
        repeat (3) @(negedge clock);
    endtask : settle
    task automatic save_cycle();
        wr_reg(`MDCR_IDX_NVCTL, 16'h0200);
        wr_reg(`MDCR_IDX_NVCTL, 16'h0000);
    endtask : save_cycle
    task automatic set_src(input int c, input logic v);
        case (c)
            0: fault_evt_hi[4] = v;
            1: fault_evt_lo[4] = v;
            2: die_temp_tap = v;
            3: clock_tap = v;
            15: fault_evt_hi[1] = v;
            16: wd_active = v;
            17: fault_evt_lo[3] = v;
            18: gate_fault_reset = v;
            19: fault_evt_lo[2] = v;
            20: q_current_tap = v;
            default: pwm_drive[c - 9] = v;
        endcase
    endtask : set_src

    initial begin
        #4_000_000;
        num_errors++;
        wrap_up();
    end

    initial begin
        logic [4:0] sel;
        rst = 1'b1;
        {external_clear_pin_n, config_unlocked, nv_store_done} = 3'b110;
        speed_voltage_code = 10'h3ff;
        {fault_evt_lo, fault_evt_hi, pwm_drive} = '0;
        {die_temp_tap, clock_tap, wd_active, gate_fault_reset, q_current_tap} = '0;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        repeat (4) @(negedge clock);
        rd_chk(`MDCR_IDX_THRESH, 16'h00ae);
        rd_chk(`MDCR_IDX_RUN, 16'h0092);
        rd_chk(`MDCR_IDX_MASK, 16'h0000);
        rd_chk(`MDCR_IDX_NVCTL, 16'h0000);
        rd_chk(8'h10, 16'h0000);
        speed_voltage_code = 10'h0ae;
        settle();
        check("low_power", low_power_mode, 1'b1);
        speed_voltage_code = 10'h0af;
        settle();
        check("low_power", low_power_mode, 1'b0);
        wr_reg(`MDCR_IDX_THRESH, 16'hfc55);
        rd_chk(`MDCR_IDX_THRESH, 16'h0055);
        u_host.wr(`MDCR_DEV_ADDR ^ 7'h01, `MDCR_IDX_THRESH, 16'h0000, ok);
        check("foreign ack", ok, 1'b0);
        rd_chk(`MDCR_IDX_THRESH, 16'h0055);
        wr_reg(`MDCR_IDX_MASK, 16'hffff);
        rd_chk(`MDCR_IDX_MASK, 16'h03f8);
        fault_evt_lo = 7'h40;
        settle();
        check("switch_off", power_switch_off, 1'b0);
        wr_reg(`MDCR_IDX_MASK, 16'h0000);
        check("switch_off", power_switch_off, 1'b1);
        fault_evt_lo = 7'h00;
        fault_evt_hi = 5'h10;
        settle();
        fault_evt_hi = 5'h00;
        rd_chk(`MDCR_IDX_FAULT_OUTPUT_PIN, 16'h8200);
        rd_chk(`MDCR_IDX_THRESH, 16'h8055);
        external_clear_pin_n = 1'b0;
        wr_reg(`MDCR_IDX_RUN, 16'h00ff);
        check("run outs", {gate_standby, dc_align_start, restart_enable, brake, direction,
              motor_run}, 6'h1f);
        // restart bit alone: latch select zero must hold restart off
        wr_reg(`MDCR_IDX_RUN, 16'h0008);
        check("run outs", {gate_standby, dc_align_start, restart_enable, brake, direction,
              motor_run}, 6'h20);
        rd_chk(`MDCR_IDX_FAULT_OUTPUT_PIN, 16'h0000);
        fault_evt_lo = 7'h01;
        settle();
        check("switch_off", power_switch_off, 1'b0);
        fault_evt_lo = 7'h00;
        external_clear_pin_n = 1'b1;
        save_cycle();
        check("store starts", starts, 1);
        nv_store_done = 1'b1;
        @(negedge clock);
        nv_store_done = 1'b0;
        rd_chk(`MDCR_IDX_NVCTL, 16'h0001);
        config_unlocked = 1'b0;
        save_cycle();
        check("store starts", starts, 1);
        config_unlocked = 1'b1;
        wr_reg(`MDCR_IDX_RUN, 16'h0001);
        save_cycle();
        check("store starts", starts, 1);
        // gaps 4..8 have no source to drive
        for (int c = 0; c < 21; c++) begin
            if (c < 4 || c > 8) begin
                sel = 5'(c);
                wr_reg(`MDCR_IDX_FAULT_OUTPUT_PIN, {11'h000, sel[4:2], 2'b00});
                wr_reg(`MDCR_IDX_RUN, {6'h00, sel[1:0], 8'h00});
                set_src(c, 1'b1);
                settle();
                check($sformatf("pin %0d", c), fault_output_pin_n, 1'b0);
                set_src(c, 1'b0);
                settle();
                check($sformatf("pin %0d", c), fault_output_pin_n, 1'b1);
            end
        end
        // reserved code 24: no source may pull the pin
        wr_reg(`MDCR_IDX_FAULT_OUTPUT_PIN, 16'h0018);
        {fault_evt_lo, fault_evt_hi, pwm_drive} = '1;
        {die_temp_tap, clock_tap, wd_active, gate_fault_reset, q_current_tap} = '1;
        settle();
        check("pin reserved", fault_output_pin_n, 1'b1);
        {fault_evt_lo, fault_evt_hi, pwm_drive} = '0;
        {die_temp_tap, clock_tap, wd_active, gate_fault_reset, q_current_tap} = '0;
        wrap_up();
    end
endmodule : testbench
